// >>> drs_pkg.sv
package drs_pkg;

    // timebase
    localparam int CLK_KHZ = 25000;

    // release timeout, both outputs
    localparam int TIMEOUT_MS = 140;
    localparam int TIMEOUT_CYC = TIMEOUT_MS * CLK_KHZ;

    // extended pushbutton setup options, least values
    localparam int SETUP_K_MS = 6720;
    localparam int SETUP_L_MS = 4480;
    localparam int SETUP_S_MS = 2240;
    localparam int SETUP_T_MS = 1120;
    localparam int SETUP_K_CYC = SETUP_K_MS * CLK_KHZ;
    localparam int SETUP_L_CYC = SETUP_L_MS * CLK_KHZ;
    localparam int SETUP_S_CYC = SETUP_S_MS * CLK_KHZ;
    localparam int SETUP_T_CYC = SETUP_T_MS * CLK_KHZ;

    // counter width, holds the longest setup count
    localparam int CNT_W = 28;

    // setup option select encoding
    localparam int SEL_W = 2;
    localparam logic [SEL_W-1:0] SEL_K = 2'h0;
    localparam logic [SEL_W-1:0] SEL_L = 2'h1;
    localparam logic [SEL_W-1:0] SEL_S = 2'h2;
    localparam logic [SEL_W-1:0] SEL_T = 2'h3;

    // synchroniser bundle layout
    localparam int SYNC_W = 7;
    localparam int IDX_VCC = 0;
    localparam int IDX_AUX = 1;
    localparam int IDX_PB = 2;
    localparam int IDX_COMB = 3;
    localparam int IDX_OD = 4;
    localparam int IDX_SEL = 5;
    localparam logic [SYNC_W-1:0] SYNC_RST = 7'h04;

endpackage

// >>> drs_tmr_if.sv
`timescale 1ns/1ps
interface drs_tmr_if;
    logic hold;
    logic active;

    modport ctl
    (
        output hold,
        input active
    );

    modport tmr
    (
        input hold,
        output active
    );
endinterface

// >>> drs_hold_timer.sv
`timescale 1ns/1ps
module drs_hold_timer
#(
    parameter int LIMIT = drs_pkg::TIMEOUT_CYC
)
(
    // clock and reset
    input wire logic ref_clk_i,
    input wire logic rst_n_i,
    // hold request and active flag
    drs_tmr_if.tmr tmr
);
    import drs_pkg::*;

    logic [CNT_W-1:0] cnt_q;
    logic [CNT_W-1:0] cnt_d;
    logic busy_q;
    logic busy_d;
    wire logic at_last = (cnt_q == CNT_W'(LIMIT - 1));

    // hold restarts the count, release after LIMIT idle cycles
    always_comb
    begin
        cnt_d = cnt_q;
        busy_d = busy_q;
        if (tmr.hold)
        begin
            cnt_d = '0;
            busy_d = 1'b1;
        end
        else if (busy_q)
        begin
            if (at_last)
                busy_d = 1'b0;
            else
                cnt_d = cnt_q + CNT_W'(1);
        end
    end

    always_ff @(posedge ref_clk_i)
    begin
        if (!rst_n_i)
        begin
            cnt_q <= '0;
            busy_q <= 1'b1;
        end
        else
        begin
            cnt_q <= cnt_d;
            busy_q <= busy_d;
        end
    end

    assign tmr.active = busy_q;

    default clocking @(posedge ref_clk_i); endclocking
    default disable iff (!rst_n_i);

    property p_release_at_limit;
        $fell(busy_q) |-> ($past(cnt_q) == CNT_W'(LIMIT - 1)) && !$past(tmr.hold);
    endproperty
    a_release_at_limit: assert property (p_release_at_limit)
        else $error("timer released before full timeout");

    property p_restart;
        tmr.hold |=> busy_q && (cnt_q == '0);
    endproperty
    a_restart: assert property (p_restart)
        else $error("timer not restarted by hold");

    property p_keep_busy;
        busy_q && !tmr.hold && !at_last |=> busy_q;
    endproperty
    a_keep_busy: assert property (p_keep_busy)
        else $error("timer dropped early");

endmodule

// >>> drs_supervisor.sv
// Behaviour
// - undervoltage on either input asserts system reset
// - system reset holds 140ms after recovery
// - independent variant: pushbutton ignored for system reset
// - combined variant: long press asserts system reset
// - long-press reset releases 140ms after button release
// - soft reset asserts at once on press
// - soft reset holds 140ms after button release
// - active low outputs, push-pull or open-drain
// - four selectable extended setup periods
// - timeout between 140 and 280 ms
`timescale 1ns/1ps
module drs_supervisor
#(
    parameter int RST_TIMEOUT_CYC = drs_pkg::TIMEOUT_CYC,
    parameter int SETUP_K_CYC_P = drs_pkg::SETUP_K_CYC,
    parameter int SETUP_L_CYC_P = drs_pkg::SETUP_L_CYC,
    parameter int SETUP_S_CYC_P = drs_pkg::SETUP_S_CYC,
    parameter int SETUP_T_CYC_P = drs_pkg::SETUP_T_CYC
)
(
    // clock and reset
    input wire logic ref_clk_i,
    input wire logic rst_n_i,
    // undervoltage indications, high when low supply
    input wire logic vcc_low_i,
    input wire logic aux_voltage_sense_i,
    // pushbutton, low when pressed
    input wire logic pushbutton_in_n_i,
    // variant straps
    input wire logic combined_i,
    input wire logic open_drain_i,
    input wire logic [drs_pkg::SEL_W-1:0] setup_sel_i,
    // system reset output pin
    output logic sys_reset_out_n_o,
    output logic sys_reset_oe_o,
    // soft reset output pin
    output logic soft_reset_out_n_o,
    output logic soft_reset_oe_o
);
    import drs_pkg::*;

    drs_tmr_if sys_if ();
    drs_tmr_if soft_if ();

    logic [SYNC_W-1:0] meta_q;
    logic [SYNC_W-1:0] sync_q;
    logic [CNT_W-1:0] setup_cnt_q;
    logic [CNT_W-1:0] setup_cnt_d;
    logic long_q;
    logic long_d;
    logic sys_n_q;
    logic sys_oe_q;
    logic soft_n_q;
    logic soft_oe_q;

    // setup count limit for the selected option
    function automatic logic [CNT_W-1:0] setup_limit(input logic [SEL_W-1:0] sel);
        logic [CNT_W-1:0] lim;
        lim = CNT_W'(SETUP_K_CYC_P);
        if (sel == SEL_L)
            lim = CNT_W'(SETUP_L_CYC_P);
        else if (sel == SEL_S)
            lim = CNT_W'(SETUP_S_CYC_P);
        else if (sel == SEL_T)
            lim = CNT_W'(SETUP_T_CYC_P);
        return lim;
    endfunction

    // two-flop synchroniser for all input pins except ref_clk_i and rst_n_i
    wire logic [SYNC_W-1:0] raw_in = {setup_sel_i, open_drain_i, combined_i,
                                      pushbutton_in_n_i, aux_voltage_sense_i, vcc_low_i};

    always_ff @(posedge ref_clk_i)
    begin
        if (!rst_n_i)
        begin
            meta_q <= SYNC_RST;
            sync_q <= SYNC_RST;
        end
        else
        begin
            meta_q <= raw_in;
            sync_q <= meta_q;
        end
    end

    wire logic uv_s = sync_q[IDX_VCC] | sync_q[IDX_AUX];
    wire logic pb_low = !sync_q[IDX_PB];
    wire logic comb_s = sync_q[IDX_COMB];
    wire logic od_s = sync_q[IDX_OD];
    wire logic [SEL_W-1:0] sel_s = sync_q[IDX_SEL +: SEL_W];

    wire logic [CNT_W-1:0] setup_lim = setup_limit(sel_s);
    wire logic setup_hit = (setup_cnt_q == setup_lim - CNT_W'(1));

    // press duration counter, saturates once long press seen
    always_comb
    begin
        setup_cnt_d = setup_cnt_q;
        long_d = long_q;
        if (!pb_low)
        begin
            setup_cnt_d = '0;
            long_d = 1'b0;
        end
        else if (!long_q)
        begin
            if (setup_hit)
                long_d = 1'b1;
            else
                setup_cnt_d = setup_cnt_q + CNT_W'(1);
        end
    end

    always_ff @(posedge ref_clk_i)
    begin
        if (!rst_n_i)
        begin
            setup_cnt_q <= '0;
            long_q <= 1'b0;
        end
        else
        begin
            setup_cnt_q <= setup_cnt_d;
            long_q <= long_d;
        end
    end

    assign sys_if.hold = uv_s | (comb_s & long_q);
    assign soft_if.hold = pb_low;

    drs_hold_timer #(
        .LIMIT(RST_TIMEOUT_CYC)
    ) u_sys_tmr (
        .ref_clk_i(ref_clk_i),
        .rst_n_i(rst_n_i),
        .tmr(sys_if)
    );

    drs_hold_timer #(
        .LIMIT(RST_TIMEOUT_CYC)
    ) u_soft_tmr (
        .ref_clk_i(ref_clk_i),
        .rst_n_i(rst_n_i),
        .tmr(soft_if)
    );

    always_ff @(posedge ref_clk_i)
    begin
        if (!rst_n_i)
        begin
            sys_n_q <= 1'b0;
            sys_oe_q <= 1'b1;
            soft_n_q <= 1'b0;
            soft_oe_q <= 1'b1;
        end
        else
        begin
            sys_n_q <= od_s ? 1'b0 : !sys_if.active;
            sys_oe_q <= od_s ? sys_if.active : 1'b1;
            soft_n_q <= od_s ? 1'b0 : !soft_if.active;
            soft_oe_q <= od_s ? soft_if.active : 1'b1;
        end
    end

    assign sys_reset_out_n_o = sys_n_q;
    assign sys_reset_oe_o = sys_oe_q;
    assign soft_reset_out_n_o = soft_n_q;
    assign soft_reset_oe_o = soft_oe_q;

    default clocking @(posedge ref_clk_i); endclocking
    default disable iff (!rst_n_i);

    sequence s_sys_low_2;
        ##2 (sys_reset_oe_o && !sys_reset_out_n_o);
    endsequence

    sequence s_soft_low_2;
        ##2 (soft_reset_oe_o && !soft_reset_out_n_o);
    endsequence

    property p_uv_asserts;
        uv_s |-> s_sys_low_2;
    endproperty
    a_uv_asserts: assert property (p_uv_asserts)
        else $error("undervoltage did not drive system reset low");

    property p_indep_ignores_pb;
        !comb_s && !uv_s && !sys_if.active |=> !sys_if.active;
    endproperty
    a_indep_ignores_pb: assert property (p_indep_ignores_pb)
        else $error("pushbutton affected system reset in independent variant");

    property p_long_asserts;
        comb_s && long_q && pb_low |-> s_sys_low_2;
    endproperty
    a_long_asserts: assert property (p_long_asserts)
        else $error("long press did not drive system reset low");

    property p_long_release;
        comb_s && long_q && !pb_low |=> !long_q && sys_if.active ##1
            (sys_reset_oe_o && !sys_reset_out_n_o);
    endproperty
    a_long_release: assert property (p_long_release)
        else $error("long-press reset not held after button release");

    property p_press_soft;
        pb_low |-> s_soft_low_2;
    endproperty
    a_press_soft: assert property (p_press_soft)
        else $error("press did not drive soft reset low");

    property p_open_drain;
        od_s |=> !sys_reset_out_n_o && !soft_reset_out_n_o &&
            (sys_reset_oe_o == $past(sys_if.active)) &&
            (soft_reset_oe_o == $past(soft_if.active));
    endproperty
    a_open_drain: assert property (p_open_drain)
        else $error("open-drain output drove high or floated while asserted");

    property p_setup_limit;
        $rose(long_q) |-> ($past(setup_cnt_q) + CNT_W'(1)) == $past(setup_lim);
    endproperty
    a_setup_limit: assert property (p_setup_limit)
        else $error("long press flagged at wrong setup count");

endmodule

// >>> drs_partner.sv
`timescale 1ns/1ps
module drs_partner
(
    // reset pins as driven by the supervisor
    input wire logic sys_out_n_i,
    input wire logic sys_oe_i,
    input wire logic soft_out_n_i,
    input wire logic soft_oe_i,
    // levels seen by the processor reset and interrupt inputs
    output logic sys_pin_o,
    output logic soft_pin_o
);
    assign sys_pin_o = sys_oe_i ? sys_out_n_i : 1'b1;
    assign soft_pin_o = soft_oe_i ? soft_out_n_i : 1'b1;
endmodule

// >>> test_dual_reset_supervisor_timing.sv
`timescale 1ns/1ps
module test_dual_reset_supervisor_timing;
    import drs_pkg::*;
    localparam int TO = 20;
    localparam int LIM [4] = '{40, 30, 20, 10};
    logic ref_clk_i = 1'b0;
    logic rst_n_i = 1'b0;
    logic vcc_low_i = 1'b0;
    logic aux_i = 1'b0;
    logic pb_n_i = 1'b1;
    logic comb_i = 1'b0;
    logic od_i = 1'b0;
    logic [SEL_W-1:0] sel_i = SEL_K;
    logic sys_n;
    logic sys_oe;
    logic soft_n;
    logic soft_oe;
    logic sys_pin;
    logic soft_pin;
    int fails = 0;
    int total_checks = 0;
    int cyc = 0;

    always #20 ref_clk_i = ~ref_clk_i;

    drs_supervisor #(
        .RST_TIMEOUT_CYC(TO),
        .SETUP_K_CYC_P(40),
        .SETUP_L_CYC_P(30),
        .SETUP_S_CYC_P(20),
        .SETUP_T_CYC_P(10)
    ) drs_supervisor_i (
        .ref_clk_i(ref_clk_i),
        .rst_n_i(rst_n_i),
        .vcc_low_i(vcc_low_i),
        .aux_voltage_sense_i(aux_i),
        .pushbutton_in_n_i(pb_n_i),
        .combined_i(comb_i),
        .open_drain_i(od_i),
        .setup_sel_i(sel_i),
        .sys_reset_out_n_o(sys_n),
        .sys_reset_oe_o(sys_oe),
        .soft_reset_out_n_o(soft_n),
        .soft_reset_oe_o(soft_oe)
    );

    drs_partner drs_partner_i (
        .sys_out_n_i(sys_n),
        .sys_oe_i(sys_oe),
        .soft_out_n_i(soft_n),
        .soft_oe_i(soft_oe),
        .sys_pin_o(sys_pin),
        .soft_pin_o(soft_pin)
    );

    task automatic report_and_stop();
        $display("checks %0d, mismatches %0d", total_checks, fails);
        if (fails == 0 && total_checks > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp)
        begin
            fails++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic tick();
        @(posedge ref_clk_i);
        #1;
    endtask

    // edges until the chosen pin reaches a level
    task automatic wait_pin(input bit sys, input logic lvl, output int n);
        n = 0;
        while (((sys ? sys_pin : soft_pin) !== lvl) && n < 400)
        begin
            tick();
            n++;
        end
    endtask

    task automatic in_range(input int n, input int lo, input int hi);
        check({31'h0, (n >= lo && n <= hi)}, 32'h1);
    endtask

    task automatic t_undervolt(input bit aux);
        int n;
        @(posedge ref_clk_i);
        if (aux)
            aux_i <= 1'b1;
        else
            vcc_low_i <= 1'b1;
        wait_pin(1'b1, 1'b0, n);
        in_range(n, 1, 4);
        check(soft_pin, 1'b1);
        repeat (10) tick();
        @(posedge ref_clk_i);
        aux_i <= 1'b0;
        vcc_low_i <= 1'b0;
        wait_pin(1'b1, 1'b1, n);
        in_range(n, TO, TO + 4);
    endtask

    task automatic t_restart();
        int n;
        @(posedge ref_clk_i);
        vcc_low_i <= 1'b1;
        wait_pin(1'b1, 1'b0, n);
        @(posedge ref_clk_i);
        vcc_low_i <= 1'b0;
        repeat (10) tick();
        @(posedge ref_clk_i);
        aux_i <= 1'b1;
        repeat (2) tick();
        @(posedge ref_clk_i);
        aux_i <= 1'b0;
        wait_pin(1'b1, 1'b1, n);
        in_range(n, TO, TO + 4);
    endtask

    task automatic t_press(input logic c, input int s, input int len);
        int n;
        int m;
        @(posedge ref_clk_i);
        comb_i <= c;
        sel_i <= s[SEL_W-1:0];
        repeat (4) tick();
        @(posedge ref_clk_i);
        pb_n_i <= 1'b0;
        wait_pin(1'b0, 1'b0, n);
        in_range(n, 1, 4);
        if (len == 0)
        begin
            wait_pin(1'b1, 1'b0, m);
            in_range(n + m, LIM[s], LIM[s] + 6);
        end
        else
        begin
            repeat (len) tick();
            check(sys_pin, 1'b1);
        end
        @(posedge ref_clk_i);
        pb_n_i <= 1'b1;
        wait_pin(1'b0, 1'b1, n);
        in_range(n, TO, TO + 4);
        wait_pin(1'b1, 1'b1, m);
        if (len == 0)
            in_range(n + m, TO, TO + 6);
        else
            check(m, 0);
    endtask

    task automatic t_open_drain();
        int n;
        @(posedge ref_clk_i);
        od_i <= 1'b1;
        repeat (4) tick();
        check({sys_oe, sys_n, soft_oe, soft_n, sys_pin}, 5'h01);
        t_undervolt(1'b0);
        @(posedge ref_clk_i);
        vcc_low_i <= 1'b1;
        wait_pin(1'b1, 1'b0, n);
        check({sys_oe, sys_n}, 2'h2);
        @(posedge ref_clk_i);
        vcc_low_i <= 1'b0;
        od_i <= 1'b0;
        wait_pin(1'b1, 1'b1, n);
        check({sys_oe, sys_n, soft_oe, soft_n}, 4'hf);
    endtask

    // mid-run reset drives both pins low, then power-up timeout
    task automatic t_reset();
        int n;
        @(posedge ref_clk_i);
        rst_n_i <= 1'b0;
        repeat (3) tick();
        check({sys_pin, soft_pin}, 2'h0);
        @(posedge ref_clk_i);
        rst_n_i <= 1'b1;
        wait_pin(1'b1, 1'b1, n);
        in_range(n, TO, TO + 6);
        wait_pin(1'b0, 1'b1, n);
        check(n, 0);
    endtask

    always @(posedge ref_clk_i)
    begin
        cyc++;
        if (cyc == 20000)
        begin
            fails++;
            report_and_stop();
        end
    end

    initial
    begin
        int n;
        repeat (11) tick();
        check({sys_pin, soft_pin}, 2'h0);
        @(posedge ref_clk_i);
        rst_n_i <= 1'b1;
        wait_pin(1'b1, 1'b1, n);
        in_range(n, TO, TO + 6);
        wait_pin(1'b0, 1'b1, n);
        t_undervolt(1'b0);
        t_undervolt(1'b1);
        t_restart();
        t_press(1'b0, 3, 60);
        t_press(1'b1, 0, 5);
        for (int s = 0; s < 4; s++)
            t_press(1'b1, s, 0);
        t_reset();
        t_open_drain();
        report_and_stop();
    end
endmodule
